// ---- hdl/ditr_regs.sv ----
// module: integration test control and ownership tag registers on avalon-mm
`timescale 1ns/1ps

// How it works
// RQ1: integration_mode_control bit 0 high puts the pins in integration mode, low is normal.
// RQ2: in integration mode software drives covered outputs and samples covered inputs.
// RQ3: output-drive register values reach the pins only while the mode bit is set.
// RQ4: output-drive bit 9 sets the restart acknowledge pin and resets to 0.
// RQ5: output-drive bit 4 set to 1 pulls the active-low perf monitor interrupt low; reset 1.
// RQ6: output-drive bit 0 sets debug acknowledge; other bits are reserved and read zero.
// RQ7: input-sample reads fast interrupt in bit 2, interrupt in 1, debug request in 0.
// RQ8: the three integration registers are not reachable from the coprocessor port.
// RQ9: writing ones to ownership_tag_set sets the matching of eight tags.
// RQ10: reading ownership_tag_set returns all eight tag bits as one.
// RQ11: writing ones to ownership_tag_clear clears the matching tags.
// RQ12: reading ownership_tag_clear returns the tags with upper bits zero.
// RQ13: a debug logic reset clears all ownership tags.
// RQ14: with the mode bit low, functional logic drives the covered output pins.
module ditr_regs (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          dbg_logic_rst,
    // avalon-mm slave
    input  wire logic [ditr_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    // coprocessor register port
    input  wire logic [ditr_pkg::ADDR_W-1:0]   cp_address,
    input  wire logic                          cp_read,
    input  wire logic                          cp_write,
    input  wire logic [31:0]                   cp_writedata,
    output logic      [31:0]                   cp_readdata,
    // functional values of the covered outputs
    input  wire logic                          func_restart_ack,
    input  wire logic                          func_perf_irq_n,
    input  wire logic                          func_debug_ack,
    // pins
    output logic                               restart_acknowledge_out,
    output logic                               perf_monitor_interrupt_n,
    output logic                               debug_acknowledge_out,
    input  wire logic                          fast_interrupt_n,
    input  wire logic                          interrupt_request_n,
    input  wire logic                          external_debug_request,
    output logic                               integration_mode
);

    logic        resp_q;
    logic        mode_en_q;
    logic        out_restart_q;
    logic        out_pmu_q;
    logic        out_debug_acknowledge_out_q;
    logic [7:0]  tags_q;
    logic [2:0]  pin_s1_q;
    logic [2:0]  pin_s2_q;
    logic        acc_wr;
    logic        acc_rd;
    logic        cp_wr;
    logic [31:0] rd_d;
    logic [31:0] cp_rd_d;
    logic [7:0]  set_mask;
    logic [7:0]  clr_mask;

    // one wait cycle: request taken on the edge where waitrequest is low
    assign avs_waitrequest = (avs_read | avs_write) & ~resp_q;
    assign acc_wr          = avs_write & resp_q;
    assign acc_rd          = avs_read & resp_q;
    assign cp_wr           = cp_write;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resp_q <= 1'b0;
        end else begin
            resp_q <= (avs_read | avs_write) & ~resp_q;
        end
    end

    // integration mode enable, bus only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_en_q <= ditr_pkg::RST_MODE_EN;
        end else if (acc_wr && avs_address == ditr_pkg::ADDR_MODE_CTRL
                     && avs_byteenable[0]) begin
            mode_en_q <= avs_writedata[ditr_pkg::MODE_EN_BIT]; // [RQ1] [RQ8]
        end
    end

    // output drive register, bus only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_restart_q <= ditr_pkg::RST_RESTART; // [RQ4]
            out_pmu_q     <= ditr_pkg::RST_PMU;     // [RQ5]
            out_debug_acknowledge_out_q  <= ditr_pkg::RST_DEBUG_ACKNOWLEDGE_OUT;
        end else if (acc_wr && avs_address == ditr_pkg::ADDR_OUT_DRIVE) begin
            if (avs_byteenable[1]) begin
                out_restart_q <= avs_writedata[ditr_pkg::OUT_RESTART_BIT]; // [RQ4] [RQ8]
            end
            if (avs_byteenable[0]) begin
                out_pmu_q    <= avs_writedata[ditr_pkg::OUT_PMU_BIT];      // [RQ5]
                out_debug_acknowledge_out_q <= avs_writedata[ditr_pkg::OUT_DEBUG_ACKNOWLEDGE_OUT_BIT];   // [RQ6]
            end
        end
    end

    // tag set and clear masks from either access path
    always_comb begin
        set_mask = '0;
        clr_mask = '0;
        if (acc_wr && avs_byteenable[0]) begin
            if (avs_address == ditr_pkg::ADDR_TAG_SET) begin
                set_mask = avs_writedata[7:0]; // [RQ9]
            end else if (avs_address == ditr_pkg::ADDR_TAG_CLEAR) begin
                clr_mask = avs_writedata[7:0]; // [RQ11]
            end
        end
        if (cp_wr) begin
            if (cp_address == ditr_pkg::ADDR_TAG_SET) begin
                set_mask = set_mask | cp_writedata[7:0]; // [RQ9]
            end else if (cp_address == ditr_pkg::ADDR_TAG_CLEAR) begin
                clr_mask = clr_mask | cp_writedata[7:0]; // [RQ11]
            end
        end
    end

    // ownership tags; a set in the same cycle wins over a clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tags_q <= ditr_pkg::RST_TAGS;
        end else if (dbg_logic_rst) begin
            tags_q <= ditr_pkg::RST_TAGS; // [RQ13]
        end else begin
            tags_q <= (tags_q & ~clr_mask) | set_mask; // [RQ9] [RQ11]
        end
    end

    // input pins pass two flip-flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {fast_interrupt_n, interrupt_request_n, external_debug_request};
            pin_s2_q <= pin_s1_q;
        end
    end

    // bus read mux
    always_comb begin
        rd_d = ditr_pkg::UNMAPPED_READ;
        if (avs_address == ditr_pkg::ADDR_OUT_DRIVE) begin
            rd_d[ditr_pkg::OUT_RESTART_BIT] = out_restart_q; // [RQ6]
            rd_d[ditr_pkg::OUT_PMU_BIT]     = out_pmu_q;
            rd_d[ditr_pkg::OUT_DEBUG_ACKNOWLEDGE_OUT_BIT]  = out_debug_acknowledge_out_q;
        end else if (avs_address == ditr_pkg::ADDR_IN_SAMPLE) begin
            rd_d[ditr_pkg::IN_FIQ_BIT]  = pin_s2_q[2]; // [RQ7] [RQ2]
            rd_d[ditr_pkg::IN_IRQ_BIT]  = pin_s2_q[1];
            rd_d[ditr_pkg::IN_EDBG_BIT] = pin_s2_q[0];
        end else if (avs_address == ditr_pkg::ADDR_MODE_CTRL) begin
            rd_d[ditr_pkg::MODE_EN_BIT] = mode_en_q;
        end else if (avs_address == ditr_pkg::ADDR_TAG_SET) begin
            rd_d[7:0] = ditr_pkg::TAGS_ALL_ONES; // [RQ10]
        end else if (avs_address == ditr_pkg::ADDR_TAG_CLEAR) begin
            rd_d[7:0] = tags_q; // [RQ12]
        end
    end

    // coprocessor read mux: integration registers read zero
    always_comb begin
        cp_rd_d = ditr_pkg::UNMAPPED_READ;
        if (cp_address == ditr_pkg::ADDR_TAG_SET) begin
            cp_rd_d[7:0] = ditr_pkg::TAGS_ALL_ONES; // [RQ10] [RQ8]
        end else if (cp_address == ditr_pkg::ADDR_TAG_CLEAR) begin
            cp_rd_d[7:0] = tags_q; // [RQ12]
        end
    end

    // read data registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
            cp_readdata  <= '0;
        end else begin
            if (avs_read && !resp_q) begin
                avs_readdata <= rd_d;
            end
            if (cp_read) begin
                cp_readdata <= cp_rd_d;
            end
        end
    end

    // covered output pins
    always_comb begin
        if (mode_en_q) begin
            restart_acknowledge_out  = out_restart_q; // [RQ3] [RQ4] [RQ2]
            perf_monitor_interrupt_n = ~out_pmu_q;    // [RQ5]
            debug_acknowledge_out    = out_debug_acknowledge_out_q;  // [RQ6]
        end else begin
            restart_acknowledge_out  = func_restart_ack; // [RQ14] [RQ1]
            perf_monitor_interrupt_n = func_perf_irq_n;
            debug_acknowledge_out    = func_debug_ack;
        end
    end
    assign integration_mode = mode_en_q;

    // checks: bus handshake steps
    sequence s_req_first;
        (avs_read || avs_write) && !resp_q;
    endsequence

    sequence s_req_taken;
        (avs_read || avs_write) && resp_q && !avs_waitrequest;
    endsequence

    // first cycle of a request always waits
    a_wait_first: assert property (@(posedge mclk) disable iff (rst)
        s_req_first |-> avs_waitrequest)
        else $error("no wait state on first request cycle");

    // second cycle of a held request is taken
    a_wait_then_take: assert property (@(posedge mclk) disable iff (rst)
        s_req_first ##1 (avs_read || avs_write) |-> !avs_waitrequest)
        else $error("held request not taken");

    a_idle_no_wait: assert property (@(posedge mclk) disable iff (rst)
        (!avs_read && !avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");

    a_take_one_cycle: assert property (@(posedge mclk) disable iff (rst)
        s_req_taken |=> !resp_q)
        else $error("response state not cleared");

    // checks: covered output pins
    a_mode_pins_int: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
        mode_en_q |-> (perf_monitor_interrupt_n == ~out_pmu_q)
                      && (restart_acknowledge_out == out_restart_q)
                      && (debug_acknowledge_out == out_debug_acknowledge_out_q))
        else $error("integration value not on pins");

    a_mode_pins_fun: assert property (@(posedge mclk) disable iff (rst) // [RQ14]
        !mode_en_q |-> (debug_acknowledge_out == func_debug_ack)
                       && (perf_monitor_interrupt_n == func_perf_irq_n)
                       && (restart_acknowledge_out == func_restart_ack))
        else $error("functional value not on pins");

    a_pmu_drive_low: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
        (acc_wr && avs_address == ditr_pkg::ADDR_OUT_DRIVE && avs_byteenable[0]
         && avs_writedata[ditr_pkg::OUT_PMU_BIT] && mode_en_q)
        |=> !perf_monitor_interrupt_n || !mode_en_q)
        else $error("perf interrupt not low");

    a_pmu_release: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
        (acc_wr && avs_address == ditr_pkg::ADDR_OUT_DRIVE && avs_byteenable[0]
         && !avs_writedata[ditr_pkg::OUT_PMU_BIT] && mode_en_q)
        |=> perf_monitor_interrupt_n || !mode_en_q)
        else $error("perf interrupt not released");

    a_restart_drive: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
        (acc_wr && avs_address == ditr_pkg::ADDR_OUT_DRIVE && avs_byteenable[1])
        |=> (restart_acknowledge_out == $past(avs_writedata[ditr_pkg::OUT_RESTART_BIT]))
            || !mode_en_q)
        else $error("restart acknowledge not driven");

    a_debug_acknowledge_out_drive: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
        (acc_wr && avs_address == ditr_pkg::ADDR_OUT_DRIVE && avs_byteenable[0])
        |=> (debug_acknowledge_out == $past(avs_writedata[ditr_pkg::OUT_DEBUG_ACKNOWLEDGE_OUT_BIT]))
            || !mode_en_q)
        else $error("debug acknowledge not driven");

    a_mode_write: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
        (acc_wr && avs_address == ditr_pkg::ADDR_MODE_CTRL && avs_byteenable[0])
        |=> mode_en_q == $past(avs_writedata[ditr_pkg::MODE_EN_BIT]))
        else $error("mode bit not written");

    // checks: coprocessor path cannot touch integration state
    a_cp_mode_keep: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        (cp_write && !acc_wr) |=> $stable(mode_en_q))
        else $error("mode bit changed from coprocessor");

    a_cp_out_keep: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        (cp_write && !acc_wr) |=> $stable(out_restart_q) && $stable(out_pmu_q)
                                  && $stable(out_debug_acknowledge_out_q))
        else $error("output register changed from coprocessor");

    // checks: ownership tags
    a_tag_set_bits: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
        (!dbg_logic_rst && set_mask != 8'h00) |=> ((tags_q & $past(set_mask))
                                                   == $past(set_mask)))
        else $error("tag not set");

    a_tag_clear_bits: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
        (!dbg_logic_rst && set_mask == 8'h00 && clr_mask != 8'h00)
        |=> ((tags_q & $past(clr_mask)) == 8'h00))
        else $error("tag not cleared");

    // written zeros leave every tag alone
    a_tag_zero_keep: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
        (!dbg_logic_rst && set_mask == 8'h00 && clr_mask == 8'h00) |=> $stable(tags_q))
        else $error("tag changed without a one written");

    a_tag_dbg_reset: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
        dbg_logic_rst |=> tags_q == ditr_pkg::RST_TAGS)
        else $error("tags survive debug reset");

    // checks: read data
    a_set_reads_ones: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
        (avs_read && !resp_q && avs_address == ditr_pkg::ADDR_TAG_SET)
        |=> avs_readdata == {24'h0, ditr_pkg::TAGS_ALL_ONES})
        else $error("set register not all ones");

    a_cp_set_ones: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
        (cp_read && cp_address == ditr_pkg::ADDR_TAG_SET)
        |=> cp_readdata == {24'h0, ditr_pkg::TAGS_ALL_ONES})
        else $error("set register not all ones on coprocessor");

    a_input_sample: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
        (avs_read && !resp_q && avs_address == ditr_pkg::ADDR_IN_SAMPLE)
        |=> avs_readdata == {29'h0, $past(pin_s2_q)})
        else $error("input sample wrong");

    a_cp_no_integ: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        (cp_read && cp_address <= ditr_pkg::ADDR_MODE_CTRL)
        |=> cp_readdata == ditr_pkg::UNMAPPED_READ)
        else $error("integration register seen from coprocessor");

    a_clear_reads: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
        (avs_read && !resp_q && avs_address == ditr_pkg::ADDR_TAG_CLEAR)
        |=> avs_readdata == {24'h0, $past(tags_q)})
        else $error("clear register read wrong");

    a_cp_clear_reads: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
        (cp_read && cp_address == ditr_pkg::ADDR_TAG_CLEAR)
        |=> cp_readdata == {24'h0, $past(tags_q)})
        else $error("clear register read wrong on coprocessor");

    a_out_reads: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
        (avs_read && !resp_q && avs_address == ditr_pkg::ADDR_OUT_DRIVE)
        |=> avs_readdata == {22'h0, $past(out_restart_q), 4'h0, $past(out_pmu_q),
                             3'h0, $past(out_debug_acknowledge_out_q)})
        else $error("output register read wrong");

endmodule : ditr_regs

// ---- hdl/ditr_pkg.sv ----
// package: register map, field positions and reset values of the integration/tag block
package ditr_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          TAG_W           = 8;
    // word addresses (byte address / 4)
    localparam logic [3:0]  ADDR_OUT_DRIVE  = 4'h0;
    localparam logic [3:0]  ADDR_IN_SAMPLE  = 4'h1;
    localparam logic [3:0]  ADDR_MODE_CTRL  = 4'h2;
    localparam logic [3:0]  ADDR_TAG_SET    = 4'h3;
    localparam logic [3:0]  ADDR_TAG_CLEAR  = 4'h4;
    // field positions
    localparam int          MODE_EN_BIT     = 0;
    localparam int          OUT_DEBUG_ACKNOWLEDGE_OUT_BIT  = 0;
    localparam int          OUT_PMU_BIT     = 4;
    localparam int          OUT_RESTART_BIT = 9;
    localparam int          IN_EDBG_BIT     = 0;
    localparam int          IN_IRQ_BIT      = 1;
    localparam int          IN_FIQ_BIT      = 2;
    // reset values
    localparam logic        RST_RESTART     = 1'b0;
    localparam logic        RST_PMU         = 1'b1;
    localparam logic        RST_DEBUG_ACKNOWLEDGE_OUT      = 1'b0;
    localparam logic        RST_MODE_EN     = 1'b0;
    localparam logic [7:0]  RST_TAGS        = 8'h00;
    localparam logic [7:0]  TAGS_ALL_ONES   = 8'hff;
    localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
endpackage : ditr_pkg

// ---- test/ditr_dbg_master.sv ----
// debugger-side avalon-mm master model for the integration/tag block
`timescale 1ns/1ps
module ditr_dbg_master (
    input  wire logic                        mclk,
    output logic [ditr_pkg::ADDR_W-1:0]      avs_address,
    output logic                             avs_read,
    output logic                             avs_write,
    output logic [31:0]                      avs_writedata,
    output logic [3:0]                       avs_byteenable,
    input  wire logic [31:0]                 avs_readdata,
    input  wire logic                        avs_waitrequest
);
    int stalls = 0; // transfers that needed more than one wait cycle
    // idle bus at time zero
    initial begin
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hf;
    end
    // hold request until waitrequest low at a rising edge, take data there
    task automatic wait_accept(output logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            @(posedge mclk);
        end
        if (n > 1) stalls++;
        d = avs_readdata;
    endtask : wait_accept
    // one write transfer
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] unused;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_accept(unused);
        avs_write     <= 1'b0;
        avs_writedata <= ~d; // released data no longer shows the old value
    endtask : bus_write
    // one read transfer
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_accept(d);
        avs_read    <= 1'b0;
    endtask : bus_read
endmodule : ditr_dbg_master

// ---- test/ditr_regs_bench.sv ----
// self-checking bench for the integration/tag register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ditr_regs_bench;
    typedef struct { logic [3:0] a; logic wr; logic [31:0] d; } ditr_row_s;
    logic mclk = 1'b0, rst = 1'b1, dlr = 1'b0;
    logic [3:0] avs_address, avs_byteenable, cp_address = 4'h0;
    logic avs_read, avs_write, avs_waitrequest, cp_read = 1'b0, cp_write = 1'b0;
    logic [31:0] avs_writedata, avs_readdata, cp_writedata = 32'h0, rd, cp_rd;
    logic [2:0] func = 3'b111; // restart ack, perf irq n, debug ack
    logic restart_o, perf_n_o, dbg_o, int_mode;
    int n_errors = 0, comparisons = 0;
    ditr_row_s rows [15];
    // clock
    always #5 mclk = ~mclk;
    ditr_dbg_master m (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    ditr_regs uut (.mclk(mclk), .rst(rst), .dbg_logic_rst(dlr), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cp_address(cp_address), .cp_read(cp_read),
        .cp_write(cp_write), .cp_writedata(cp_writedata), .cp_readdata(cp_rd),
        .func_restart_ack(func[2]), .func_perf_irq_n(func[1]), .func_debug_ack(func[0]),
        .restart_acknowledge_out(restart_o), .perf_monitor_interrupt_n(perf_n_o),
        .debug_acknowledge_out(dbg_o), .fast_interrupt_n(1'b1),
        .interrupt_request_n(1'b0), .external_debug_request(1'b1),
        .integration_mode(int_mode));
    // verdict and end of run
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // pin levels once settled
    task automatic pins(input logic [2:0] e);
        @(negedge mclk);
        `CHK("pins", e, {restart_o, perf_n_o, dbg_o})
    endtask : pins
    // watchdog
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
    // main sequence
    initial begin
        rows = '{'{ditr_pkg::ADDR_OUT_DRIVE, 0, 32'h10}, '{ditr_pkg::ADDR_MODE_CTRL, 0, 0},
            '{ditr_pkg::ADDR_TAG_CLEAR, 0, 0}, '{ditr_pkg::ADDR_IN_SAMPLE, 0, 32'h5},
            '{ditr_pkg::ADDR_TAG_SET, 1, 32'ha5}, '{ditr_pkg::ADDR_TAG_CLEAR, 0, 32'ha5},
            '{ditr_pkg::ADDR_TAG_SET, 0, 32'hff}, '{ditr_pkg::ADDR_TAG_CLEAR, 1, 32'h21},
            '{ditr_pkg::ADDR_TAG_CLEAR, 0, 32'h84}, '{ditr_pkg::ADDR_OUT_DRIVE, 1, '1},
            '{ditr_pkg::ADDR_OUT_DRIVE, 0, 32'h211}, '{4'h5, 1, '1}, '{4'h5, 0, 0},
            '{ditr_pkg::ADDR_MODE_CTRL, 1, 32'h1}, '{ditr_pkg::ADDR_MODE_CTRL, 0, 32'h1}};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        pins(3'b111);
        foreach (rows[i]) begin
            if (rows[i].wr) m.bus_write(rows[i].a, rows[i].d);
            else begin
                m.bus_read(rows[i].a, rd);
                `CHK("row read", rows[i].d, rd)
            end
        end
        func <= 3'b010;
        pins(3'b101);
        `CHK("mode", 1'b1, int_mode)
        m.bus_write(ditr_pkg::ADDR_OUT_DRIVE, 32'h10);
        pins(3'b000);
        @(posedge mclk);
        cp_address <= ditr_pkg::ADDR_MODE_CTRL;
        cp_write   <= 1'b1;
        @(posedge mclk);
        cp_write   <= 1'b0;
        pins(3'b000);
        `CHK("mode cp", 1'b1, int_mode)
        m.bus_write(ditr_pkg::ADDR_MODE_CTRL, 32'h0);
        pins(3'b010);
        `CHK("mode off", 1'b0, int_mode)
        @(posedge mclk);
        dlr <= 1'b1;
        @(posedge mclk);
        dlr <= 1'b0;
        m.bus_read(ditr_pkg::ADDR_TAG_CLEAR, rd);
        `CHK("tags after debug reset", 32'h0, rd)
        `CHK("bus stalls", 0, m.stalls)
        // coprocessor path: tags reachable, integration registers not
        @(posedge mclk);
        cp_address   <= ditr_pkg::ADDR_TAG_SET;
        cp_writedata <= 32'h0f;
        cp_write     <= 1'b1;
        @(posedge mclk);
        cp_write   <= 1'b0;
        cp_address <= ditr_pkg::ADDR_TAG_CLEAR;
        cp_read    <= 1'b1;
        @(posedge mclk);
        cp_address <= ditr_pkg::ADDR_OUT_DRIVE;
        @(negedge mclk);
        `CHK("cp tags", 32'h0f, cp_rd)
        @(posedge mclk);
        cp_read <= 1'b0;
        @(negedge mclk);
        `CHK("cp integration read", 32'h0, cp_rd)
        final_report();
    end
endmodule : ditr_regs_bench
